// ### include/tmw_pkg.sv
// shared constants, modes and control layout of the 8-bit waveform timer
package tmw_pkg;

  localparam int unsigned TMW_CNT_W = 8;
  localparam int unsigned TMW_PRE_W = 10;
  localparam logic [7:0] TMW_BOTTOM = 8'h00;
  localparam logic [7:0] TMW_MAX = 8'hFF;

  // register byte addresses on the bus
  localparam logic [7:0] TMW_OFS_CTRL = 8'h00;
  localparam logic [7:0] TMW_OFS_COUNT = 8'h04;
  localparam logic [7:0] TMW_OFS_COMPARE = 8'h08;
  localparam logic [7:0] TMW_OFS_FLAGS = 8'h0C;
  localparam int unsigned TMW_ADDR_W = 8;

  // flag register bit positions
  localparam int unsigned TMW_FLAG_CMP_BIT = 0;
  localparam int unsigned TMW_FLAG_OVF_BIT = 1;

  // reset values
  localparam logic [7:0] TMW_CTRL_RST = 8'h00;
  localparam logic [7:0] TMW_COUNT_RST = 8'h00;
  localparam logic [7:0] TMW_COMPARE_RST = 8'h00;
  localparam logic [31:0] TMW_RDATA_RST = 32'h0000_0000;

  // output actions
  localparam logic [1:0] TMW_ACT_OFF = 2'h0;
  localparam logic [1:0] TMW_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TMW_ACT_CLEAR = 2'h2;
  localparam logic [1:0] TMW_ACT_SET = 2'h3;

  // prescale divide ratios
  localparam int unsigned TMW_DIV_8 = 8;
  localparam int unsigned TMW_DIV_64 = 64;
  localparam int unsigned TMW_DIV_256 = 256;
  localparam int unsigned TMW_DIV_1024 = 1024;

  typedef enum logic [1:0] {
    TMW_MODE_NORMAL = 2'b00,
    TMW_MODE_PHASE = 2'b01,
    TMW_MODE_CTC = 2'b10,
    TMW_MODE_FAST = 2'b11
  } tmw_mode_t;

  typedef enum logic [2:0] {
    TMW_CLK_STOP = 3'b000,
    TMW_CLK_DIV1 = 3'b001,
    TMW_CLK_DIV8 = 3'b010,
    TMW_CLK_DIV64 = 3'b011,
    TMW_CLK_DIV256 = 3'b100,
    TMW_CLK_DIV1024 = 3'b101,
    TMW_CLK_EXT_FALL = 3'b110,
    TMW_CLK_EXT_RISE = 3'b111
  } tmw_clksel_t;

  // control register: [7] pin direction, [6:4] clock source, [3:2] action, [1:0] mode
  typedef struct packed {
    logic pin_dir;
    tmw_clksel_t clk_sel;
    logic [1:0] action;
    tmw_mode_t mode;
  } tmw_ctrl_t;

endpackage

// ### rtl/tmw_prescaler.sv
// timer clock enable from the i/o clock divider or the external count pin
`timescale 1ns/10ps
module tmw_prescaler
  import tmw_pkg::*;
#(
  parameter int unsigned PRE_W = TMW_PRE_W
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire tmw_clksel_t clk_sel_in,
  input wire logic ext_pin_in,
  output logic tick_out
);

  logic [PRE_W-1:0] div_reg;
  logic ext_prev_reg;
  logic div_tick;

  // one shared free divider: every ratio ticks on its own terminal count
  function automatic logic div_done(input logic [PRE_W-1:0] cnt, input int unsigned ratio);
    logic [PRE_W-1:0] mask;
    mask = PRE_W'(ratio - 1);
    return (cnt & mask) == mask;
  endfunction

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + PRE_W'(1);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_pin_in;
    end
  end

  always_comb begin
    div_tick = 1'b0;
    unique case (clk_sel_in)
      TMW_CLK_STOP: div_tick = 1'b0;
      TMW_CLK_DIV1: div_tick = 1'b1;
      TMW_CLK_DIV8: div_tick = div_done(div_reg, TMW_DIV_8);
      TMW_CLK_DIV64: div_tick = div_done(div_reg, TMW_DIV_64);
      TMW_CLK_DIV256: div_tick = div_done(div_reg, TMW_DIV_256);
      TMW_CLK_DIV1024: div_tick = div_done(div_reg, TMW_DIV_1024);
      TMW_CLK_EXT_FALL: div_tick = ext_prev_reg & ~ext_pin_in;
      TMW_CLK_EXT_RISE: div_tick = ~ext_prev_reg & ext_pin_in;
    endcase
  end

  assign tick_out = div_tick;

endmodule

// ### rtl/tmw_wave_gen.sv
// next level of the internal waveform output register
`timescale 1ns/10ps
module tmw_wave_gen
  import tmw_pkg::*;
(
  input wire tmw_mode_t mode_in,
  input wire logic [1:0] action_in,
  input wire logic tick_in,
  input wire logic match_in,
  input wire logic at_top_in,
  input wire logic at_bottom_in,
  input wire logic dir_up_in,
  input wire logic cmp_max_in,
  input wire logic level_in,
  output logic level_next_out
);

  always_comb begin
    level_next_out = level_in;
    if (tick_in) begin
      unique case (mode_in)
        TMW_MODE_NORMAL, TMW_MODE_CTC: begin
          if (match_in) begin
            unique case (action_in)
              TMW_ACT_OFF: level_next_out = level_in;
              TMW_ACT_TOGGLE: level_next_out = ~level_in;
              TMW_ACT_CLEAR: level_next_out = 1'b0;
              TMW_ACT_SET: level_next_out = 1'b1;
            endcase
          end
        end
        TMW_MODE_FAST: begin
          if (action_in == TMW_ACT_TOGGLE && match_in) begin
            level_next_out = ~level_in;
          end else if (action_in[1]) begin
            // the top action wins, so a compare at max is constant and at bottom a spike
            if (at_top_in) begin
              level_next_out = ~action_in[0];
            end else if (match_in) begin
              level_next_out = action_in[0];
            end
          end
        end
        TMW_MODE_PHASE: begin
          if (action_in[1]) begin
            if (at_top_in) begin
              // at max take the up-count level unless the compare sits at max
              level_next_out = cmp_max_in ? ~action_in[0] : action_in[0];
            end else if (match_in) begin
              // a match at bottom turns the count upward, so it acts as an up match
              level_next_out = (dir_up_in || at_bottom_in) ? action_in[0] : ~action_in[0];
            end
          end
        end
      endcase
    end
  end

endmodule

// ### rtl/tmw_timer.sv
// 8-bit waveform timer with ctc, fast and phase correct pwm behind an ahb-lite slave
//
// Function
// - mode 2 clears the counter after it equals compare; compare is the top.
// - clear-on-compare sets the compare flag each time top is reached.
// - clear-on-compare writes compare directly; a low write misses until wrap.
// - clear-on-compare with action 1 toggles the output on every match.
// - clear-on-compare sets overflow when counter wraps from max to zero.
// - output reaches the pin only when its direction is set to output.
// - mode 3 counts bottom to max then restarts from bottom.
// - fast pwm clears the counter on the tick after it equals max.
// - fast pwm sets overflow each time counter reaches max.
// - fast pwm action 2 clears on match, sets at wrap; action 3 opposite.
// - fast pwm compare bottom gives spike; compare max gives constant level.
// - fast pwm action 1 toggles on match while compare stays buffered.
// - mode 1 counts up to max then down to bottom, repeatedly.
// - phase correct turns at max and holds max for one tick.
// - phase correct sets overflow each time counter reaches bottom.
// - phase correct action 2 clears on up match, sets on down match.
// - phase correct compare bottom constant low, max constant high, inverted opposite.
// - phase correct at max drives the up-match level unless compare is max, also after compare leaves max.
// - phase correct missed up match still gives its output change at max.
// - pwm modes buffer compare until top; other modes take it immediately.
// - an equality sets the compare flag on the next timer tick.
// - clock source picks stopped, divide 1/8/64/256/1024, or pin edges.
`timescale 1ns/10ps
module tmw_timer
  import tmw_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  input wire logic EXT_COUNT_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  output logic WAVE_OUT,
  output logic WAVE_OE_OUT
);

  // bus slave state
  logic wr_pend_reg;
  logic [TMW_ADDR_W-1:0] wr_addr_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic addr_take;

  // software state
  tmw_ctrl_t ctrl_reg;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] cmp_buf_reg;
  logic [7:0] cmp_act_reg;
  logic dir_up_reg;
  logic cmp_flag_reg;
  logic ovf_flag_reg;
  logic block_reg;
  logic level_reg;
  logic level_next;
  logic oe_reg;

  // decoded write strobes for the data phase
  logic wr_ctrl;
  logic wr_count;
  logic wr_compare;
  logic wr_flags;

  // timer events
  logic tick;
  logic match;
  logic at_top;
  logic at_bottom;
  logic is_pwm;
  logic cmp_max;
  logic ovf_event;
  logic cmp_clear;
  logic ovf_clear;
  logic [TMW_ADDR_W-1:0] rd_addr;

  function automatic logic word_is(input logic [TMW_ADDR_W-1:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // both pwm modes share a buffered compare and a fixed top
  function automatic logic mode_is_pwm(input tmw_mode_t m);
    return (m == TMW_MODE_FAST) || (m == TMW_MODE_PHASE);
  endfunction

  // ---------------- ahb-lite slave ----------------
  // only single word transfers; unmapped addresses read zero, writes dropped
  // hsize is not checked, so a narrow write still loads the whole low byte
  assign addr_take = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
  assign rd_addr = HADDR_IN[TMW_ADDR_W-1:0];

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else begin
      wr_pend_reg <= addr_take & HWRITE_IN;
      if (addr_take) begin
        wr_addr_reg <= HADDR_IN[TMW_ADDR_W-1:0];
      end
    end
  end

  assign wr_ctrl = wr_pend_reg & word_is(wr_addr_reg, TMW_OFS_CTRL);
  assign wr_count = wr_pend_reg & word_is(wr_addr_reg, TMW_OFS_COUNT);
  assign wr_compare = wr_pend_reg & word_is(wr_addr_reg, TMW_OFS_COMPARE);
  assign wr_flags = wr_pend_reg & word_is(wr_addr_reg, TMW_OFS_FLAGS);

  // read data is fetched at the address edge so the slave never waits
  // a read taken as a write lands returns the old value
  always_comb begin
    rdata_next = TMW_RDATA_RST;
    if (word_is(rd_addr, TMW_OFS_CTRL)) begin
      rdata_next = {24'h00_0000, ctrl_reg};
    end else if (word_is(rd_addr, TMW_OFS_COUNT)) begin
      rdata_next = {24'h00_0000, count_reg};
    end else if (word_is(rd_addr, TMW_OFS_COMPARE)) begin
      rdata_next = {24'h00_0000, cmp_buf_reg};
    end else if (word_is(rd_addr, TMW_OFS_FLAGS)) begin
      rdata_next = {30'h0000_0000, ovf_flag_reg, cmp_flag_reg};
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdata_reg <= TMW_RDATA_RST;
    end else if (addr_take & ~HWRITE_IN) begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      HREADYOUT_OUT <= 1'b0;
      HRESP_OUT <= 1'b0;
    end else begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
    end
  end

  assign HRDATA_OUT = rdata_reg;

  // ---------------- control register ----------------
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl_reg <= tmw_ctrl_t'(TMW_CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_reg <= tmw_ctrl_t'(HWDATA_IN[7:0]);
    end
  end

  // ---------------- timer clock enable ----------------
  // the divider runs from reset, so the first tick after a select is not aligned
  tmw_prescaler #(
    .PRE_W(TMW_PRE_W)
  ) u_prescaler (
    .clk_in(CORE_CLK_IN),
    .rst_in(RST_IN),
    .clk_sel_in(ctrl_reg.clk_sel),
    .ext_pin_in(EXT_COUNT_IN),
    .tick_out(tick)
  );

  // ---------------- compare and counter events ----------------
  assign is_pwm = mode_is_pwm(ctrl_reg.mode);
  assign at_top = tick & (count_reg == TMW_MAX);
  assign at_bottom = (count_reg == TMW_BOTTOM);
  // a count write removes the match on the following tick
  assign match = tick & ~block_reg & (count_reg == cmp_act_reg);
  // at top the buffered value is the one that takes over
  assign cmp_max = ((at_top & is_pwm) ? cmp_buf_reg : cmp_act_reg) == TMW_MAX;

  // the block lasts until a tick, even while the clock is stopped
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      block_reg <= 1'b0;
    end else if (wr_count) begin
      block_reg <= 1'b1;
    end else if (tick) begin
      block_reg <= 1'b0;
    end
  end

  // ---------------- counting sequence ----------------
  always_comb begin
    count_next = count_reg;
    if (tick) begin
      unique case (ctrl_reg.mode)
        TMW_MODE_NORMAL: count_next = count_reg + 8'h01;
        TMW_MODE_CTC: begin
          if (match) begin
            count_next = TMW_BOTTOM;
          end else begin
            count_next = count_reg + 8'h01;
          end
        end
        TMW_MODE_FAST: begin
          if (count_reg == TMW_MAX) begin
            count_next = TMW_BOTTOM;
          end else begin
            count_next = count_reg + 8'h01;
          end
        end
        TMW_MODE_PHASE: begin
          // max is held for a single tick because the turn happens on leaving it
          if (dir_up_reg && count_reg != TMW_MAX) begin
            count_next = count_reg + 8'h01;
          end else if (dir_up_reg) begin
            count_next = count_reg - 8'h01;
          end else if (count_reg != TMW_BOTTOM) begin
            count_next = count_reg - 8'h01;
          end else begin
            count_next = count_reg + 8'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      count_reg <= TMW_COUNT_RST;
    end else if (wr_count) begin
      // software load beats a same-cycle tick
      count_reg <= HWDATA_IN[7:0];
    end else begin
      count_reg <= count_next;
    end
  end

  // leaving phase mode rearms the up direction for the next entry
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      dir_up_reg <= 1'b1;
    end else if (ctrl_reg.mode != TMW_MODE_PHASE) begin
      dir_up_reg <= 1'b1;
    end else if (tick && count_reg == TMW_MAX) begin
      dir_up_reg <= 1'b0;
    end else if (tick && at_bottom) begin
      dir_up_reg <= 1'b1;
    end
  end

  // ---------------- compare value ----------------
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cmp_buf_reg <= TMW_COMPARE_RST;
    end else if (wr_compare) begin
      cmp_buf_reg <= HWDATA_IN[7:0];
    end
  end

  // pwm modes wait for top to avoid odd-length pulses; others follow at once
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cmp_act_reg <= TMW_COMPARE_RST;
    end else if (!is_pwm) begin
      cmp_act_reg <= wr_compare ? HWDATA_IN[7:0] : cmp_buf_reg;
    end else if (at_top) begin
      cmp_act_reg <= cmp_buf_reg;
    end
  end

  // ---------------- flags ----------------
  always_comb begin
    unique case (ctrl_reg.mode)
      TMW_MODE_PHASE: ovf_event = tick & at_bottom & ~dir_up_reg;
      TMW_MODE_FAST: ovf_event = at_top;
      default: ovf_event = at_top;
    endcase
  end

  // write-one-clear strobes; a zero bit leaves its flag alone
  assign cmp_clear = wr_flags & HWDATA_IN[TMW_FLAG_CMP_BIT];
  assign ovf_clear = wr_flags & HWDATA_IN[TMW_FLAG_OVF_BIT];

  // hardware set wins over a same-cycle write-one clear
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cmp_flag_reg <= 1'b0;
    end else if (match) begin
      cmp_flag_reg <= 1'b1;
    end else if (cmp_clear) begin
      cmp_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ovf_flag_reg <= 1'b0;
    end else if (ovf_event) begin
      ovf_flag_reg <= 1'b1;
    end else if (ovf_clear) begin
      ovf_flag_reg <= 1'b0;
    end
  end

  // ---------------- waveform output ----------------
  // no force-compare strobe; reserved action codes leave the level as it is
  tmw_wave_gen u_wave_gen (
    .mode_in(ctrl_reg.mode),
    .action_in(ctrl_reg.action),
    .tick_in(tick),
    .match_in(match),
    .at_top_in(at_top),
    .at_bottom_in(at_bottom),
    .dir_up_in(dir_up_reg),
    .cmp_max_in(cmp_max),
    .level_in(level_reg),
    .level_next_out(level_next)
  );

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= level_next;
    end
  end

  // the level is kept across mode changes; only the pin drive is gated
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= ctrl_reg.pin_dir & (ctrl_reg.action != TMW_ACT_OFF);
    end
  end

  assign WAVE_OUT = level_reg;
  assign WAVE_OE_OUT = oe_reg;

endmodule

// ### tb/tmw_load.sv
// load model on the waveform pin: driven level, or a floating line when released
`timescale 1ns/10ps
module tmw_load (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wave_in,
  input wire logic oe_in,
  output logic pin_out
);
  logic last_reg;
  // a released line flips every cycle so a stale level never looks valid
  assign pin_out = oe_in ? wave_in : ~last_reg;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= pin_out;
    end
  end
endmodule

// ### tb/tmw_timer_chk.sv
// port assertions for the waveform timer
`timescale 1ns/10ps
module tmw_timer_chk
  import tmw_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic HREADYOUT_OUT,
  input wire logic HRESP_OUT,
  input wire logic WAVE_OUT,
  input wire logic WAVE_OE_OUT
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  logic take;
  logic ctrl_wr;
  logic mapped;
  assign take = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
  assign ctrl_wr = take && HWRITE_IN && HADDR_IN[7:0] == TMW_OFS_CTRL;
  assign mapped = HADDR_IN[7:0] inside {TMW_OFS_CTRL, TMW_OFS_COUNT, TMW_OFS_COMPARE,
    TMW_OFS_FLAGS};
  a_resp_okay: assert property (!HRESP_OUT)
    else $error("bus response not okay");
  a_ready_no_wait: assert property (!$past(RST_IN) |-> HREADYOUT_OUT)
    else $error("slave inserted a wait state");
  a_oe_follows_ctrl: assert property (
    ctrl_wr |-> ##3 WAVE_OE_OUT == ($past(HWDATA_IN[7], 2) && $past(HWDATA_IN[3:2], 2) != 2'h0))
    else $error("pin enable does not follow control");
  a_oe_change_cause: assert property ($changed(WAVE_OE_OUT) |-> $past(ctrl_wr, 3))
    else $error("pin enable moved without control write");
  a_rdata_stands: assert property (!(take && !HWRITE_IN) |=> $stable(HRDATA_OUT))
    else $error("read data changed without a read");
  a_unmapped_read_zero: assert property (take && !HWRITE_IN && !mapped |=> HRDATA_OUT == '0)
    else $error("unmapped read not zero");
  a_upper_bits_zero: assert property (HRDATA_OUT[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_reset_quiet: assert property (
    $fell(RST_IN) |-> !WAVE_OUT && !WAVE_OE_OUT && HRDATA_OUT == '0)
    else $error("outputs not cleared by reset");
  c_ctrl_write: cover property (ctrl_wr);
  c_wave_rise: cover property ($rose(WAVE_OUT) && WAVE_OE_OUT);
  c_unmapped_read: cover property (take && !HWRITE_IN && !mapped);
endmodule
bind tmw_timer tmw_timer_chk u_chk (.CORE_CLK_IN, .RST_IN, .HSEL_IN, .HADDR_IN, .HTRANS_IN,
  .HWRITE_IN, .HWDATA_IN, .HREADY_IN, .HRDATA_OUT, .HREADYOUT_OUT, .HRESP_OUT, .WAVE_OUT,
  .WAVE_OE_OUT);

// ### tb/test_timer8_waveform_modes.sv
// self-checking bench for the waveform timer
`timescale 1ns/10ps
module test_timer8_waveform_modes;
  import tmw_pkg::*;
  logic clk, rst, hsel, hwrite, ext, hready, hresp, wave, oe, pin;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  int err_count, checks, cyc, n, hi, lo;
  int dv[7] = '{1, 8, 64, 256, 1024, 6, 6};

  tmw_timer u_dut (.CORE_CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .EXT_COUNT_IN(ext), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
    .HRESP_OUT(hresp), .WAVE_OUT(wave), .WAVE_OE_OUT(oe));
  tmw_load u_load (.clk_in(clk), .rst_in(rst), .wave_in(wave), .oe_in(oe), .pin_out(pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // external count pin: an edge every 3 cycles, so one falling edge per 6
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 3 == 0) ext <= ~ext;
    if (cyc == 60000) begin
      err_count++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    checks++;
    if (got != exp) begin
      err_count++;
      $display("Error at %0t: counted %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h00_0000, d};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 8'h00);
    chk(q, e);
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // cycles until the waveform changes, sampled away from the launching edge
  task automatic gap(output int c, input int lim);
    logic v;
    v = wave;
    c = 0;
    while (wave === v && c < lim) begin
      @(negedge clk);
      c++;
    end
  endtask

  task automatic lvl(input logic v);
    @(negedge clk);
    while (wave !== v) @(negedge clk);
  endtask

  task automatic hilo;
    lvl(1'b0);
    lvl(1'b1);
    gap(hi, 3000);
    gap(lo, 3000);
  endtask

  task automatic steady(input logic v);
    repeat (1100) @(posedge clk);
    gap(n, 600);
    chk_n(n, 600);
    chk(32'(wave), 32'(v));
  endtask

  task automatic t_regs;
    do_reset();
    rd(TMW_OFS_CTRL, 32'h0000_0000);
    rd(TMW_OFS_COUNT, 32'h0000_0000);
    rd(TMW_OFS_COMPARE, 32'h0000_0000);
    rd(TMW_OFS_FLAGS, 32'h0000_0000);
    wr(8'h10, 8'hFF);
    rd(8'h10, 32'h0000_0000);
    wr(TMW_OFS_COMPARE, 8'h55);
    rd(TMW_OFS_COMPARE, 32'h0000_0055);
  endtask

  task automatic t_ctc;
    do_reset();
    wr(TMW_OFS_COMPARE, 8'h02);
    wr(TMW_OFS_CTRL, 8'h96);
    gap(n, 50);
    gap(n, 50);
    chk_n(n, 3);
    chk(32'(oe), 32'h0000_0001);
    chk(32'(pin), 32'(wave));
    rd(TMW_OFS_FLAGS, 32'h0000_0001);
    wr(TMW_OFS_CTRL, 8'h16);
    repeat (3) @(posedge clk);
    chk(32'(oe), 32'h0000_0000);
  endtask

  task automatic t_miss;
    do_reset();
    wr(TMW_OFS_COMPARE, 8'h05);
    wr(TMW_OFS_COUNT, 8'h0A);
    wr(TMW_OFS_CTRL, 8'h12);
    repeat (200) @(posedge clk);
    rd(TMW_OFS_FLAGS, 32'h0000_0000);
    repeat (100) @(posedge clk);
    rd(TMW_OFS_FLAGS, 32'h0000_0003);
  endtask

  task automatic t_clk;
    do_reset();
    for (int i = 0; i < 7; i++) begin
      wr(TMW_OFS_CTRL, {1'b1, 3'(i + 1), 4'h6});
      gap(n, 3000);
      gap(n, 3000);
      gap(n, 3000);
      chk_n(n, dv[i]);
    end
    wr(TMW_OFS_CTRL, 8'h86);
    repeat (5) @(posedge clk);
    gap(n, 200);
    chk_n(n, 200);
  endtask

  task automatic t_fast;
    do_reset();
    wr(TMW_OFS_COMPARE, 8'h40);
    for (int a = 2; a < 4; a++) begin
      wr(TMW_OFS_CTRL, {4'h9, 2'(a), 2'h3});
      hilo();
      chk_n(hi, a == 2 ? 65 : 191);
      chk_n(hi + lo, 256);
    end
    bus(TMW_OFS_FLAGS, 1'b0, 8'h00);
    chk(q & 32'h0000_0002, 32'h0000_0002);
    wr(TMW_OFS_CTRL, 8'h97);
    gap(n, 600);
    gap(n, 600);
    chk_n(n, 256);
    wr(TMW_OFS_CTRL, 8'h9B);
    wr(TMW_OFS_COMPARE, 8'h00);
    hilo();
    chk_n(hi, 1);
    chk_n(lo, 255);
    wr(TMW_OFS_COMPARE, 8'hFF);
    rd(TMW_OFS_COMPARE, 32'h0000_00FF);
    steady(1'b1);
  endtask

  task automatic t_phase;
    do_reset();
    wr(TMW_OFS_COMPARE, 8'h40);
    for (int a = 2; a < 4; a++) begin
      wr(TMW_OFS_CTRL, {4'h9, 2'(a), 2'h1});
      hilo();
      chk_n(hi, a == 2 ? 128 : 382);
      chk_n(hi + lo, 510);
    end
    bus(TMW_OFS_FLAGS, 1'b0, 8'h00);
    chk(q & 32'h0000_0002, 32'h0000_0002);
    wr(TMW_OFS_CTRL, 8'h99);
    wr(TMW_OFS_COMPARE, 8'h00);
    steady(1'b0);
    wr(TMW_OFS_COMPARE, 8'hFF);
    steady(1'b1);
    wr(TMW_OFS_COMPARE, 8'h40);
    lvl(1'b0);
    gap(n, 600);
    chk_n(n, 191);
  endtask

  task automatic t_missed_up;
    do_reset();
    wr(TMW_OFS_COMPARE, 8'h40);
    wr(TMW_OFS_COUNT, 8'h80);
    wr(TMW_OFS_CTRL, 8'h9D);
    repeat (200) @(posedge clk);
    chk(32'(wave), 32'h0000_0001);
  endtask

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    ext = 1'b0;
    err_count = 0;
    checks = 0;
    cyc = 0;
    t_regs();
    t_ctc();
    t_miss();
    t_clk();
    t_fast();
    t_phase();
    t_missed_up();
    test_done();
  end
endmodule
